// File: design/poscmp_pkg.sv
// Shared constants, register map and carrier types for the compare block.
package poscmp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Clock and timing.

   // System clock period in nanoseconds (20 MHz).
   localparam int CLOCK_PERIOD_NS = 50;
   // One step of the pulse width setting, in nanoseconds (0.1 ms).
   localparam int PULSE_STEP_NS = 100000;
   // Clock cycles per pulse width step; a least time, so it rounds up.
   localparam int PULSE_STEP_CYCLES =
      (PULSE_STEP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   // Largest pulse width setting, in steps.
   localparam logic [10:0] PULSE_WIDTH_MAX = 11'h7ff;

   ////////////////////////////////////////////////////////////////////////////
   // Comparison points.

   // Number of points held by this block (points 3 to 8).
   localparam int POINT_COUNT = 6;
   // Number of the first point held here.
   localparam int POINT_FIRST = 3;

   // Attribute codes.
   localparam logic [1:0] ATTR_SKIP    = 2'h0;
   localparam logic [1:0] ATTR_RISING  = 2'h1;
   localparam logic [1:0] ATTR_FALLING = 2'h2;
   localparam logic [1:0] ATTR_BOTH    = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, byte addresses.

   // Point n target sits at POINT_BASE + (n-3)*POINT_STRIDE.
   localparam logic [7:0] POINT_BASE      = 8'h00;
   // Distance between consecutive points.
   localparam logic [7:0] POINT_STRIDE    = 8'h08;
   // Attribute sits this far above its target.
   localparam logic [7:0] ATTR_OFFSET     = 8'h04;
   // Control register: run bit.
   localparam logic [7:0] CONTROL_ADDR    = 8'h30;
   // Output pulse width setting, 11 bits, in steps.
   localparam logic [7:0] PULSE_WIDTH_ADDR = 8'h34;
   // Status register, read only.
   localparam logic [7:0] STATUS_ADDR     = 8'h38;
   // Last sampled position, read only.
   localparam logic [7:0] POSITION_ADDR   = 8'h3c;

   // Field positions.
   localparam int CONTROL_RUN_BIT   = 0;
   localparam int STATUS_ACTIVE_BIT = 0;
   localparam int STATUS_RUN_BIT    = 1;
   localparam int STATUS_PREV_BIT   = 2;

   // Reset values.
   localparam logic [31:0] TARGET_RESET      = 32'h0000_0000;
   localparam logic [15:0] ATTR_RESET        = 16'h0000;
   localparam logic [10:0] PULSE_WIDTH_RESET = 11'h000;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Carrier types.

   // One comparison point: signed target and attribute word.
   typedef struct packed {
      logic signed [31:0] target;
      logic        [15:0] attribute;
   } point_cfg_t;

   // One sampled position with its strobe.
   typedef struct packed {
      logic               strobe;
      logic signed [31:0] value;
   } position_sample_t;

endpackage

// File: design/point_crossing.sv
// Crossing detector for one comparison point against two position samples.
`timescale 1ns/1ps
module point_crossing
   import poscmp_pkg::*;
(
   // Point setting.
   input  point_cfg_t         cfg,
   // Previous and present positions.
   input  wire logic signed [31:0] prev_pos,
   input  wire logic signed [31:0] curr_pos,
   // Qualified crossing.
   output logic               hit
);

   // Direction terms; a stop on the target and a later move away is not a
   // second crossing, because the move must start strictly off the target.
   logic rise;  // Moved from below to at or above the target.
   logic fall;  // Moved from above to at or below the target.

   // Signed comparisons decide the crossing direction.
   always_comb begin
      rise = (prev_pos < cfg.target) && (curr_pos >= cfg.target);
      fall = (prev_pos > cfg.target) && (curr_pos <= cfg.target);
      unique case (cfg.attribute[1:0])
         ATTR_SKIP: begin
            hit = 1'b0;
         end
         ATTR_RISING: begin
            hit = rise;
         end
         ATTR_FALLING: begin
            hit = fall;
         end
         ATTR_BOTH: begin
            hit = rise | fall;
         end
      endcase
   end

endmodule

// File: design/pulse_timer.sv
// Timed output pulse, counted in steps of a fixed number of clock cycles.
`timescale 1ns/1ps
module pulse_timer
   import poscmp_pkg::*;
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Start request and width in steps.
   input  wire logic        start,
   input  wire logic [10:0] width,
   // Pulse output.
   output logic             active
);

   logic [10:0] steps;           // Steps still to run.
   logic [10:0] next_steps;
   logic [11:0] cycles;          // Cycles left in the present step.
   logic [11:0] next_cycles;
   logic        next_active;

   // Loads on start, then counts cycles within steps down to zero.
   always_comb begin
      next_steps  = steps;
      next_cycles = cycles;
      next_active = active;
      if (start && !active && width != 11'h000) begin
         next_active = 1'b1;
         next_steps  = width;
         next_cycles = 12'(PULSE_STEP_CYCLES - 1);
      end else if (active) begin
         if (cycles != 12'h000) begin
            next_cycles = cycles - 12'h001;
         end else if (steps == 11'h001) begin
            next_active = 1'b0;
            next_steps  = 11'h000;
         end else begin
            next_steps  = steps - 11'h001;
            next_cycles = 12'(PULSE_STEP_CYCLES - 1);
         end
      end
   end

   // Registers the counters.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         steps  <= 11'h000;
         cycles <= 12'h000;
         active <= 1'b0;
      end else begin
         steps  <= next_steps;
         cycles <= next_cycles;
         active <= next_active;
      end
   end

endmodule

// File: design/position_compare_points.sv
// Position compare points 3 to 8 with AXI4-Lite register access.
//
// Summary of operation
// - separate target and attribute per point
// - targets are signed 32-bit values
// - attribute 0 skips the point
// - attribute 1 fires on rising crossing
// - attribute 2 fires on falling crossing
// - attribute 3 fires on either crossing
// - pulse width in 0.1 ms steps
// - no evaluation while pulse is active
// - compare feedback against targets while running
//
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module position_compare_points
   import poscmp_pkg::*;
(
   // Clock and reset.
   input  wire logic        clock,
   input  wire logic        rst_n,
   // Encoder position feedback, same clock domain.
   input  wire logic        position_strobe,
   input  wire logic [31:0] position_value,
   // Compare pulse output.
   output logic             compare_out,
   // AXI4-Lite write address channel.
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data channel.
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response channel.
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address channel.
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data channel.
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   point_cfg_t       points [POINT_COUNT];      // Point settings.
   point_cfg_t       next_points [POINT_COUNT];
   logic             run;                      // Comparison running.
   logic             next_run;
   logic [10:0]      pulse_width;              // Pulse width in steps.
   logic [10:0]      next_pulse_width;

   position_sample_t sample;                   // Carried feedback sample.
   logic signed [31:0] prev_pos;               // Previous sample.
   logic signed [31:0] next_prev_pos;
   logic signed [31:0] curr_pos;               // Present sample.
   logic signed [31:0] next_curr_pos;
   logic             prev_valid;               // Previous sample is usable.
   logic             next_prev_valid;
   logic             evaluate;                 // Samples just updated.
   logic             next_evaluate;

   logic [POINT_COUNT-1:0] hits;               // Per-point crossings.
   logic             pulse_start;              // Start of output pulse.
   logic             pulse_active;             // Output pulse running.

   // Write path holding registers.
   logic             aw_held;                  // Write address captured.
   logic             next_aw_held;
   logic [7:0]       aw_addr;                  // Captured write address.
   logic [7:0]       next_aw_addr;
   logic             w_held;                   // Write data captured.
   logic             next_w_held;
   logic [31:0]      w_data;                   // Captured write data.
   logic [31:0]      next_w_data;
   logic [3:0]       w_strb;                   // Captured byte strobes.
   logic [3:0]       next_w_strb;
   logic             next_bvalid;
   logic [1:0]       next_bresp;
   logic             next_awready;
   logic             next_wready;

   // Read path registers.
   logic             next_arready;
   logic             next_rvalid;
   logic [31:0]      next_rdata;
   logic [1:0]       next_rresp;

   ////////////////////////////////////////////////////////////////////////////
   // Point evaluation.

   // Bundles the feedback input into its carrier.
   assign sample = '{strobe: position_strobe, value: position_value};

   // Keeps two consecutive samples; history restarts whenever comparison
   // is stopped so a stale sample never forms a false crossing.
   always_comb begin
      next_prev_pos   = prev_pos;
      next_curr_pos   = curr_pos;
      next_prev_valid = prev_valid;
      next_evaluate   = 1'b0;
      if (!run) begin
         next_prev_valid = 1'b0;
      end else if (sample.strobe) begin
         next_prev_pos   = curr_pos;
         next_curr_pos   = sample.value;
         next_prev_valid = 1'b1;
         next_evaluate   = prev_valid;
      end
      if (!run && sample.strobe) begin
         next_curr_pos = sample.value;
      end
   end

   // Registers the sample history.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         prev_pos   <= 32'sh0000_0000;
         curr_pos   <= 32'sh0000_0000;
         prev_valid <= 1'b0;
         evaluate   <= 1'b0;
      end else begin
         prev_pos   <= next_prev_pos;
         curr_pos   <= next_curr_pos;
         prev_valid <= next_prev_valid;
         evaluate   <= next_evaluate;
      end
   end

   // One crossing detector per point, each on its own setting.
   for (genvar i = 0; i < POINT_COUNT; i++) begin : g_point
      point_crossing u_cross (
         .cfg      (points[i]),
         .prev_pos (prev_pos),
         .curr_pos (curr_pos),
         .hit      (hits[i])
      );
   end

   assign pulse_start = run && evaluate && !pulse_active && (|hits);

   // Timed pulse on the compare output.
   pulse_timer u_pulse (
      .clock  (clock),
      .rst_n  (rst_n),
      .start  (pulse_start),
      .width  (pulse_width),
      .active (pulse_active)
   );

   // The output comes from the timer's flip-flop.
   assign compare_out = pulse_active;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path.

   // Captures address and data in either order, then writes and answers.
   always_comb begin
      next_aw_held     = aw_held;
      next_aw_addr     = aw_addr;
      next_w_held      = w_held;
      next_w_data      = w_data;
      next_w_strb      = w_strb;
      next_bvalid      = s_axi_bvalid;
      next_bresp       = s_axi_bresp;
      next_points      = points;
      next_run         = run;
      next_pulse_width = pulse_width;
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      // Both halves held and no answer pending: perform the write.
      if (aw_held && w_held && !s_axi_bvalid) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = RESP_OKAY;
         if (aw_addr < CONTROL_ADDR) begin
            for (int i = 0; i < POINT_COUNT; i++) begin
               if (aw_addr == 8'(POINT_BASE + i * POINT_STRIDE)) begin
                  for (int b = 0; b < 4; b++) begin
                     if (w_strb[b]) begin
                        next_points[i].target[b*8 +: 8] = w_data[b*8 +: 8];
                     end
                  end
               end
               if (aw_addr == 8'(POINT_BASE + i * POINT_STRIDE
                                 + ATTR_OFFSET)) begin
                  for (int b = 0; b < 2; b++) begin
                     if (w_strb[b]) begin
                        next_points[i].attribute[b*8 +: 8] =
                           w_data[b*8 +: 8];
                     end
                  end
               end
            end
            if (aw_addr[1:0] != 2'h0) begin
               next_bresp = RESP_SLVERR;
            end
         end else if (aw_addr == CONTROL_ADDR) begin
            if (w_strb[0]) begin
               next_run = w_data[CONTROL_RUN_BIT];
            end
         end else if (aw_addr == PULSE_WIDTH_ADDR) begin
            if (w_strb[0]) begin
               next_pulse_width[7:0] = w_data[7:0];
            end
            if (w_strb[1]) begin
               next_pulse_width[10:8] = w_data[10:8];
            end
         end else if (aw_addr != STATUS_ADDR && aw_addr != POSITION_ADDR)
         begin
            next_bresp = RESP_SLVERR;
         end
      end
      next_awready = !next_aw_held;
      next_wready  = !next_w_held;
   end

   // Registers the write path and the settings.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         aw_held       <= 1'b0;
         aw_addr       <= 8'h00;
         w_held        <= 1'b0;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         run           <= 1'b0;
         pulse_width   <= PULSE_WIDTH_RESET;
         for (int i = 0; i < POINT_COUNT; i++) begin
            points[i] <= '{target: TARGET_RESET, attribute: ATTR_RESET};
         end
      end else begin
         aw_held       <= next_aw_held;
         aw_addr       <= next_aw_addr;
         w_held        <= next_w_held;
         w_data        <= next_w_data;
         w_strb        <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready  <= next_wready;
         s_axi_bvalid  <= next_bvalid;
         s_axi_bresp   <= next_bresp;
         run           <= next_run;
         pulse_width   <= next_pulse_width;
         points        <= next_points;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path.

   // Takes one read address at a time and answers on the next cycle.
   always_comb begin
      next_arready = s_axi_arready;
      next_rvalid  = s_axi_rvalid;
      next_rdata   = s_axi_rdata;
      next_rresp   = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid  = 1'b0;
         next_arready = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid  = 1'b1;
         next_rdata   = 32'h0000_0000;
         next_rresp   = RESP_SLVERR;
         for (int i = 0; i < POINT_COUNT; i++) begin
            if (s_axi_araddr == 8'(POINT_BASE + i * POINT_STRIDE)) begin
               next_rdata = points[i].target;
               next_rresp = RESP_OKAY;
            end
            if (s_axi_araddr == 8'(POINT_BASE + i * POINT_STRIDE
                                   + ATTR_OFFSET)) begin
               next_rdata = {16'h0000, points[i].attribute};
               next_rresp = RESP_OKAY;
            end
         end
         unique case (s_axi_araddr)
            CONTROL_ADDR: begin
               next_rdata[CONTROL_RUN_BIT] = run;
               next_rresp = RESP_OKAY;
            end
            PULSE_WIDTH_ADDR: begin
               next_rdata[10:0] = pulse_width;
               next_rresp = RESP_OKAY;
            end
            STATUS_ADDR: begin
               next_rdata[STATUS_ACTIVE_BIT] = pulse_active;
               next_rdata[STATUS_RUN_BIT]    = run;
               next_rdata[STATUS_PREV_BIT]   = prev_valid;
               next_rresp = RESP_OKAY;
            end
            POSITION_ADDR: begin
               next_rdata = curr_pos;
               next_rresp = RESP_OKAY;
            end
            default: begin
               next_rdata = next_rdata;
            end
         endcase
      end
   end

   // Registers the read path.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= next_arready;
         s_axi_rvalid  <= next_rvalid;
         s_axi_rdata   <= next_rdata;
         s_axi_rresp   <= next_rresp;
      end
   end

endmodule

// File: bench/position_compare_points_properties.sv
// Port checks for the compare block, bound to its top module.
`timescale 1ns/1ps
module position_compare_points_properties
   import poscmp_pkg::*;
(
   // Clock and reset.
   input wire logic        clock,
   input wire logic        rst_n,
   // Position feedback and pulse.
   input wire logic        position_strobe,
   input wire logic        compare_out,
   // Register bus.
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // Cycles the pulse has stood high so far.
   logic [22:0] hi_count;
   // Count while high; low or reset clears it.
   always_ff @(posedge clock) begin
      hi_count <= (rst_n && compare_out) ? hi_count + 23'h1 : 23'h0;
   end
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   property p_whole_steps;
      $fell(compare_out) |-> (hi_count % 2000) == 0;
   endproperty
   a_whole_steps: assert property (p_whole_steps)
      else $error("pulse length not whole steps");
   property p_min_step;
      (compare_out && hi_count < 1999) |=> compare_out;
   endproperty
   a_min_step: assert property (p_min_step)
      else $error("pulse shorter than one step");
   property p_from_sample;
      $rose(compare_out) |-> $past(position_strobe, 2);
   endproperty
   a_from_sample: assert property (p_from_sample)
      else $error("pulse without a new sample");
   property p_read_answer;
      (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid;
   endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read answer late");
   property p_read_holds;
      (s_axi_rvalid && !s_axi_rready) |=>
         s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_read_holds: assert property (p_read_holds)
      else $error("read answer dropped");
   property p_write_answer;
      (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready)
         |-> ##2 s_axi_bvalid;
   endproperty
   a_write_answer: assert property (p_write_answer)
      else $error("write answer late");
   property p_write_holds;
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_write_holds: assert property (p_write_holds)
      else $error("write answer dropped");
   property p_one_write;
      (s_axi_awvalid && s_axi_awready) |=> !s_axi_awready;
   endproperty
   a_one_write: assert property (p_one_write)
      else $error("second write accepted");
endmodule
bind position_compare_points position_compare_points_properties
   position_compare_points_properties_i (.clock(clock), .rst_n(rst_n),
   .position_strobe(position_strobe), .compare_out(compare_out),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));

// File: bench/encoder_feed.sv
// Encoder feedback model that hands position samples to the block.
`timescale 1ns/1ps
module encoder_feed (
   // Clock.
   input wire logic    clock,
   // Sample strobe and value.
   output logic        position_strobe = 1'b0,
   output logic [31:0] position_value = 32'h0
);
   // Offer one sample; off the strobe the value is scrambled on purpose.
   task automatic send(input logic [31:0] v);
      @(posedge clock);
      position_strobe <= 1'b1;
      position_value <= v;
      @(posedge clock);
      position_strobe <= 1'b0;
      position_value <= ~v;
   endtask
endmodule

// File: bench/position_compare_points_test.sv
// Self-checking testbench for the compare point block.
`timescale 1ns/1ps
module position_compare_points_test;
   import poscmp_pkg::*;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic position_strobe;
   logic [31:0] position_value;
   logic compare_out;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   int errors = 0;
   int checks_done = 0;
   logic [31:0] tgt [6];
   // Free-running system clock.
   always #25 clock = ~clock;
   position_compare_points position_compare_points_i (.clock(clock),
      .rst_n(rst_n), .position_strobe(position_strobe),
      .position_value(position_value), .compare_out(compare_out),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready));
   encoder_feed encoder_feed_i (.clock(clock),
      .position_strobe(position_strobe), .position_value(position_value));
   ////////////////////////////////////////////////////////////////////////////
   // Compare one value and count it.
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Byte address of a point's target.
   function automatic logic [7:0] ta(input int k);
      return 8'(POINT_BASE + POINT_STRIDE * 8'(k));
   endfunction
   // Register write with response check.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s = 4'hf);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check("write response", 32'(RESP_OKAY), 32'(s_axi_bresp));
   endtask
   // Register read with data and response check.
   task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] exp_resp);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check("read response", 32'(exp_resp), 32'(s_axi_rresp));
      check("read data", exp, s_axi_rdata);
   endtask
   // Count pulse cycles over a slightly longer window.
   task automatic pulse(input int exp_len);
      int n;
      n = 0;
      repeat (exp_len + 8) begin
         @(posedge clock);
         n += int'(compare_out === 1'b1);
      end
      check("pulse length", 32'(exp_len), 32'(n));
   endtask
   // Print the counts and the verdict, then stop.
   task automatic summarize;
      $display("checks %0d mismatches %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence.
   initial begin
      int p, code;
      for (int k = 0; k < 6; k++)
         tgt[k] = 32'(k * 1000 - 2500);
      tgt[0] = 32'h8000_0001;
      tgt[5] = 32'h7fff_fffe;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      repeat (2) @(posedge clock);
      for (int k = 0; k < 6; k++) begin
         rd(ta(k), 32'h0, RESP_OKAY);
         rd(ta(k) + ATTR_OFFSET, 32'h0, RESP_OKAY);
      end
      rd(8'h40, 32'h0, RESP_SLVERR);
      $display("test reset values done");
      // Distinct pairs per point, read back; attributes keep only their low 16 bits.
      for (int k = 0; k < 6; k++) begin
         wr(ta(k), tgt[k]);
         wr(ta(k) + ATTR_OFFSET, 32'h1234_abcc);
      end
      for (int k = 0; k < 6; k++) begin
         rd(ta(k), tgt[k], RESP_OKAY);
         rd(ta(k) + ATTR_OFFSET, 32'h0000_abcc, RESP_OKAY);
      end
      // Byte strobes change only the lanes they select.
      wr(ta(0), 32'hffff_ff5a, 4'h1);
      rd(ta(0), {tgt[0][31:8], 8'h5a}, RESP_OKAY);
      wr(ta(0), tgt[0]);
      $display("test point storage done");
      // Every code in both directions, one point active at a time.
      wr(PULSE_WIDTH_ADDR, 32'h1);
      for (int i = 0; i < 8; i++) begin
         p = (i + 1) % 6;
         code = i / 2;
         wr(ta(p) + ATTR_OFFSET, 32'(code));
         wr(CONTROL_ADDR, 32'h1);
         encoder_feed_i.send(i[0] ? tgt[p] - 32'h1 : tgt[p] + 32'h1);
         encoder_feed_i.send(i[0] ? tgt[p] + 32'h1 : tgt[p] - 32'h1);
         pulse((code == 3 || (code == 1 && i[0]) || (code == 2 && !i[0])) ?
            PULSE_STEP_CYCLES : 0);
         wr(CONTROL_ADDR, 32'h0);
         wr(ta(p) + ATTR_OFFSET, 32'h0);
      end
      $display("test attribute codes done");
      // Signed compare, two-step pulse, crossing lost during the pulse.
      wr(PULSE_WIDTH_ADDR, 32'h2);
      wr(POINT_BASE + POINT_STRIDE + ATTR_OFFSET, 32'(ATTR_BOTH));
      wr(CONTROL_ADDR, 32'h1);
      encoder_feed_i.send(32'h0000_0005);
      encoder_feed_i.send(32'hffff_fffb);
      pulse(0);
      encoder_feed_i.send(32'hffff_f830);
      fork
         pulse(2 * PULSE_STEP_CYCLES);
         begin
            repeat (50) @(posedge clock);
            encoder_feed_i.send(32'h0);
         end
      join
      pulse(0);
      encoder_feed_i.send(32'hffff_f830);
      pulse(2 * PULSE_STEP_CYCLES);
      $display("test pulse suspension done");
      summarize();
   end
   // Cut a hang short.
   initial begin
      repeat (40000) @(posedge clock);
      errors++;
      summarize();
   end
endmodule
